/* rtl/vpit_pkg.sv */
// Notes on behaviour
// (RQ1) Level 3 requests win over level 2, level 2 over 1, 1 over 0.
// (RQ2) Within one level the smallest vector number wins.
// (RQ3) Each entry takes two words; address is base plus twice vector number.
// (RQ4) Table entries reach only a 19-bit target address.
// (RQ5) Vector address is relative to a programmable table base.
// (RQ6) Chip reset uses vector 0, watchdog reset vector 1, overlaying reset base.
// (RQ7) Software puts jumps in entries 0 and 1, subroutine calls elsewhere.
// (RQ8) Core exceptions use vectors 2 to 9 at fixed level 3.
// (RQ9) Peripheral sources 0x0A to 0x21 default to level 0, reassignable.
// (RQ10) Peripheral sources map onto vectors 10 to 24 and 33.
// (RQ11) Timer channels use vectors 25 and 26; six port interrupts 27 to 32.
// (RQ12) Soft interrupts 0..3 use vectors 40..43 levels 0..3; 44 is lowest.
// (RQ13) User interrupts on vectors 45 to 47 sit at fixed level 1.
// (RQ14) User interrupts on vectors 48 to 50 sit at fixed level 2.
// (RQ15) Vector 50 is fast unless its entry holds a subroutine call.
// (RQ16) Vectors 34 to 39 are reserved and never issued.
// (RQ17) A request stays pending until the core acknowledges its fetch.
package vpit_pkg;
    localparam int          VPIT_NUM_VEC      = 51;
    localparam int          VPIT_VEC_W        = 6;
    localparam int          VPIT_ADDR_W       = 19;
    localparam int          VPIT_LVL_W        = 3;
    // Levels are biased by one so that level -1 encodes as zero
    localparam logic [2:0]  VPIT_LVL_LOWEST   = 3'h0;
    localparam logic [2:0]  VPIT_LVL_0        = 3'h1;
    localparam logic [2:0]  VPIT_LVL_1        = 3'h2;
    localparam logic [2:0]  VPIT_LVL_2        = 3'h3;
    localparam logic [2:0]  VPIT_LVL_3        = 3'h4;
    localparam int          VPIT_CORE_FIRST   = 2;
    localparam int          VPIT_CORE_LAST    = 9;
    localparam int          VPIT_PERI_FIRST   = 10;
    localparam int          VPIT_PERI_LAST    = 33;
    localparam int          VPIT_RSV_FIRST    = 34;
    localparam int          VPIT_RSV_LAST     = 39;
    localparam int          VPIT_SOFT_FIRST   = 40;
    localparam int          VPIT_SOFT_LOWEST  = 44;
    localparam int          VPIT_USR1_FIRST   = 45;
    localparam int          VPIT_USR2_FIRST   = 48;
    localparam logic [5:0]  VPIT_VEC_RESET    = 6'h00;
    localparam logic [5:0]  VPIT_VEC_WDOG     = 6'h01;
    localparam logic [5:0]  VPIT_VEC_FAST     = 6'h32;
    localparam int          VPIT_PERI_N       = VPIT_PERI_LAST - VPIT_PERI_FIRST + 1;
    localparam logic [18:0] VPIT_BASE_RESET   = 19'h00000;

    typedef enum logic [1:0] {
        VPIT_IDLE  = 2'b00,
        VPIT_OFFER = 2'b01,
        VPIT_RESET = 2'b10
    } vpit_state_e;

    typedef struct packed {
        logic        valid;
        logic [5:0]  vec;
        logic [18:0] addr;
        logic        fast;
    } vpit_vec_s;
endpackage

/* rtl/vpit_table.sv */
`timescale 1ns/1ps
module vpit_table
    import vpit_pkg::*;
#(
    parameter int PERI_N = VPIT_PERI_N
) (
    input  wire logic                     CORE_CLK_IN,
    input  wire logic                     RST_N_IN,
    input  wire logic [VPIT_NUM_VEC-1:0]  REQ_IN,
    input  wire logic [2*PERI_N-1:0]      PERI_LEVEL_IN,
    input  wire logic [VPIT_ADDR_W-1:0]   VECTOR_TABLE_BASE_IN,
    input  wire logic                     FAST_ENTRY_IN,
    input  wire logic                     WATCHDOG_TIMEOUT_IN,
    input  wire logic                     ACK_IN,
    output logic                          VEC_VALID_OUT,
    output logic [VPIT_VEC_W-1:0]         VEC_NUM_OUT,
    output logic [VPIT_ADDR_W-1:0]        VEC_ADDR_OUT,
    output logic                          VEC_FAST_OUT,
    output logic [VPIT_NUM_VEC-1:0]       PENDING_OUT
);
    initial begin
        if (PERI_N != VPIT_PERI_N) $error("PERI_N must match peripheral span");
    end

    // ==============================================================
    // Level of each vector
    logic [VPIT_LVL_W-1:0] lvl [VPIT_NUM_VEC];
    always_comb begin
        for (int v = 0; v < VPIT_NUM_VEC; v++) begin
            lvl[v] = VPIT_LVL_0;
            if (v >= VPIT_CORE_FIRST && v <= VPIT_CORE_LAST)
                lvl[v] = VPIT_LVL_3;                                   // [RQ8]
            else if (v >= VPIT_PERI_FIRST && v <= VPIT_PERI_LAST)
                lvl[v] = VPIT_LVL_0 + 3'(PERI_LEVEL_IN[2*(v-VPIT_PERI_FIRST) +: 2]); // [RQ9] [RQ10] [RQ11]
            else if (v >= VPIT_SOFT_FIRST && v < VPIT_SOFT_LOWEST)
                lvl[v] = VPIT_LVL_0 + 3'(v - VPIT_SOFT_FIRST);        // [RQ12]
            else if (v == VPIT_SOFT_LOWEST)
                lvl[v] = VPIT_LVL_LOWEST;                              // [RQ12]
            else if (v >= VPIT_USR1_FIRST && v < VPIT_USR2_FIRST)
                lvl[v] = VPIT_LVL_1;                                   // [RQ13]
            else if (v >= VPIT_USR2_FIRST)
                lvl[v] = VPIT_LVL_2;                                   // [RQ14]
        end
    end

    // ==============================================================
    // Pending latches and arbitration
    logic [VPIT_NUM_VEC-1:0] pend_r, pend_nxt, live;
    vpit_vec_s               win;
    logic [VPIT_LVL_W-1:0]   best;
    vpit_state_e             state_r, state_nxt;
    vpit_vec_s               out_r, out_nxt;

    always_comb begin
        live = pend_r | REQ_IN;
        for (int v = VPIT_RSV_FIRST; v <= VPIT_RSV_LAST; v++)
            live[v] = 1'b0;                                            // [RQ16]
        live[VPIT_VEC_RESET] = 1'b0;
        live[VPIT_VEC_WDOG]  = 1'b0;
        win  = '0;
        best = '0;
        // Descending scan so the lowest vector overwrites at equal level
        for (int v = VPIT_NUM_VEC - 1; v >= 0; v--) begin
            if (live[v] && (!win.valid || lvl[v] >= best)) begin      // [RQ1] [RQ2]
                win.valid = 1'b1;
                win.vec   = 6'(v);
                best      = lvl[v];
            end
        end
        // Only 19 address bits; wrap beyond is the user's limitation
        win.addr = VECTOR_TABLE_BASE_IN + {12'h000, win.vec, 1'b0};   // [RQ3] [RQ4] [RQ5]
        win.fast = (win.vec == VPIT_VEC_FAST) && FAST_ENTRY_IN;       // [RQ15]
    end

    always_comb begin
        state_nxt = state_r;
        out_nxt   = out_r;
        pend_nxt  = live;                                              // [RQ17]
        case (state_r)
            VPIT_RESET: begin
                // Entry 0 fetch after chip reset; entry addresses overlay reset base
                out_nxt = '{1'b1, VPIT_VEC_RESET, VECTOR_TABLE_BASE_IN, 1'b0}; // [RQ6] [RQ7]
                if (out_r.valid && ACK_IN) begin
                    state_nxt = VPIT_IDLE;
                    out_nxt   = '0;
                end
            end
            VPIT_IDLE: begin
                if (WATCHDOG_TIMEOUT_IN) begin
                    out_nxt   = '{1'b1, VPIT_VEC_WDOG,
                                  VECTOR_TABLE_BASE_IN + {12'h000, VPIT_VEC_WDOG, 1'b0}, 1'b0}; // [RQ6]
                    state_nxt = VPIT_OFFER;
                end else if (win.valid) begin
                    out_nxt   = win;
                    state_nxt = VPIT_OFFER;
                end
            end
            VPIT_OFFER: begin
                // Offer is frozen until acknowledged; re-arbitration waits
                if (ACK_IN) begin                                      // [RQ17]
                    pend_nxt[out_r.vec] = 1'b0;
                    if (REQ_IN[out_r.vec] && out_r.vec > VPIT_VEC_WDOG)
                        pend_nxt[out_r.vec] = 1'b1;
                    out_nxt   = '0;
                    state_nxt = VPIT_IDLE;
                end
            end
            default: begin
                state_nxt = VPIT_IDLE;
                out_nxt   = '0;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_N_IN) begin
            state_r <= VPIT_RESET;
            out_r   <= '0;
            pend_r  <= '0;
        end else begin
            state_r <= state_nxt;
            out_r   <= out_nxt;
            pend_r  <= pend_nxt;
        end
    end

    assign VEC_VALID_OUT = out_r.valid;
    assign VEC_NUM_OUT   = out_r.vec;
    assign VEC_ADDR_OUT  = out_r.addr;
    assign VEC_FAST_OUT  = out_r.fast;
    assign PENDING_OUT   = pend_r;
endmodule

/* tb/vpit_table_monitor.sv */
`timescale 1ns/1ps
module vpit_table_monitor #(parameter int PERI_N = 24) (
    input wire logic                CORE_CLK_IN,
    input wire logic                RST_N_IN,
    input wire logic                FAST_ENTRY_IN,
    input wire logic                WATCHDOG_TIMEOUT_IN,
    input wire logic                ACK_IN,
    input wire logic                VEC_VALID_OUT,
    input wire logic                VEC_FAST_OUT,
    input wire logic [50:0]         REQ_IN,
    input wire logic [50:0]         PENDING_OUT,
    input wire logic [2*PERI_N-1:0] PERI_LEVEL_IN,
    input wire logic [18:0]         VECTOR_TABLE_BASE_IN,
    input wire logic [18:0]         VEC_ADDR_OUT,
    input wire logic [5:0]          VEC_NUM_OUT
);
    default clocking @(posedge CORE_CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    // ========================================
    // Offer and pending-latch checks
    a_reset_fetch: assert property ($rose(RST_N_IN) |=>
        VEC_VALID_OUT && VEC_NUM_OUT == 6'h00) else $error("no reset fetch");
    a_addr_calc: assert property (VEC_VALID_OUT |->
        VEC_ADDR_OUT == VECTOR_TABLE_BASE_IN + {VEC_NUM_OUT, 1'b0}) else $error("bad address");
    a_no_reserved: assert property (VEC_VALID_OUT |->
        !(VEC_NUM_OUT inside {[6'h22:6'h27]})) else $error("reserved vector");
    a_offer_holds: assert property (VEC_VALID_OUT && !ACK_IN |=>
        VEC_VALID_OUT && $stable(VEC_NUM_OUT)) else $error("offer dropped");
    a_ack_clears: assert property (VEC_VALID_OUT && ACK_IN |=>
        !VEC_VALID_OUT) else $error("offer kept after ack");
    a_fast_vector: assert property (VEC_FAST_OUT |->
        VEC_VALID_OUT && VEC_NUM_OUT == 6'h32) else $error("fast on wrong vector");
    a_core_first: assert property ($rose(VEC_VALID_OUT) && VEC_NUM_OUT > 6'h09 |->
        $past(PENDING_OUT[9:2]) == 8'h00) else $error("core exception skipped");
    a_req_latch: assert property (REQ_IN[33:2] != 32'h0 |=>
        (PENDING_OUT[33:2] & $past(REQ_IN[33:2])) == $past(REQ_IN[33:2])) else $error("lost");
endmodule
bind vpit_table vpit_table_monitor #(.PERI_N(PERI_N)) u_vpit_table_monitor (.*);

/* tb/vpit_core_model.sv */
`timescale 1ns/1ps
module vpit_core_model (
    input  wire logic       clk_in,
    input  wire logic       valid_in,
    input  wire logic [1:0] dly_in,
    output logic            ack_out = 1'b0
);
    logic [2:0] wait_r = 3'h0;
    // ========================================
    // Core fetch: one-cycle accept after a chosen wait, never twice per offer
    always @(negedge clk_in) begin
        wait_r <= (valid_in && !ack_out) ? wait_r + 3'h1 : 3'h0;
        ack_out <= valid_in && !ack_out && wait_r >= {1'b0, dly_in};
    end
endmodule

/* tb/vpit_table_tb.sv */
`timescale 1ns/1ps
module vpit_table_tb;
    logic        clk = 1'b0, rst_n = 1'b0, wdog = 1'b0, ack, valid, vfast;
    logic        fast = 1'b1; // Entry 50 holds a plain jump
    logic [50:0] req = '0, pend;
    logic [47:0] lvl = 48'hC00000000000; // Vector 33 raised to level 3
    logic [18:0] base = 19'h00000, vaddr;
    logic [5:0]  vnum, v, e, q[$];
    logic [1:0]  dly = 2'h0;
    logic [25:0] x;
    int          seed = 13246, n_fail = 0, num_checks = 0, cyc = 0, k;
    int          vl[11] = '{2, 33, 43, 42, 49, 50, 41, 45, 12, 40, 44};
    always #50 clk = ~clk;
    vpit_table u_vpit_table (.CORE_CLK_IN(clk), .RST_N_IN(rst_n), .REQ_IN(req),
        .PERI_LEVEL_IN(lvl), .VECTOR_TABLE_BASE_IN(base), .FAST_ENTRY_IN(fast),
        .WATCHDOG_TIMEOUT_IN(wdog), .ACK_IN(ack), .VEC_VALID_OUT(valid), .VEC_NUM_OUT(vnum),
        .VEC_ADDR_OUT(vaddr), .VEC_FAST_OUT(vfast), .PENDING_OUT(pend));
    vpit_core_model u_vpit_core_model (.clk_in(clk), .valid_in(valid), .dly_in(dly),
        .ack_out(ack));
    task automatic close_out;
        // Expectations never answered count against the run
        if (q.size() != 0)
            n_fail++;
        $display("checks %0d fails %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Idle means nothing expected and no offer standing
    task automatic drain(input string name);
        for (k = 0; k < 300 && (q.size() != 0 || valid !== 1'b0); k++) @(negedge clk);
        $display("test %s done", name);
    endtask
    always @(posedge clk) begin
        cyc++;
        if (valid === 1'b1 && ack === 1'b1) begin
            e = (q.size() > 0) ? q.pop_front() : 6'h3F;
            x = {fast && e == 6'h32, e, base + {e, 1'b0}};
            num_checks++;
            if ({vfast, vnum, vaddr} !== x) begin
                n_fail++;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, {vfast, vnum, vaddr}, x);
            end
        end
        if (cyc == 3000) begin
            n_fail++;
            close_out();
        end
    end
    initial begin
        base = 19'($random(seed));
        q.push_back(6'h00);
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        drain("reset");
        foreach (vl[i]) begin
            req[vl[i]] = 1'b1;
            q.push_back(6'(vl[i]));
        end
        req[35] = 1'b1;
        req[1] = 1'b1;
        @(negedge clk);
        req = '0;
        drain("priority");
        wdog = 1'b1;
        req[27] = 1'b1;
        q.push_back(6'h01);
        q.push_back(6'h1B);
        @(negedge clk);
        {wdog, req} = '0;
        drain("watchdog");
        // Entry 50 now holds a subroutine call, so no fast flag
        fast = 1'b0;
        req[50] = 1'b1;
        q.push_back(6'h32);
        @(negedge clk);
        req = '0;
        drain("slow entry");
        fast = 1'b1;
        for (int i = 0; i < 8; i++) begin
            v = 6'(10 + {$random(seed)} % 24);
            dly = 2'($random(seed));
            req[v] = 1'b1;
            q.push_back(v);
            @(negedge clk);
            req = '0;
            drain("single");
        end
        // Second reset in mid-run must offer the reset entry again
        rst_n = 1'b0;
        q.push_back(6'h00);
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        drain("rerun");
        close_out();
    end
endmodule
